/* dcs_addr_step.sv */
`timescale 1ns/1ps
// ==========================================================================
// Next address of one pointer after one transfer unit.
module dcs_addr_step
  import dcs_pkg::*;
(
  input wire logic [31:0] addr, // Present address.
  input wire dcs_pkg::dcs_amode_t mode, // Address mode.
  input wire logic [1:0] tw, // Transfer width: 0 byte, 1 half, 2 word.
  input wire logic [7:0] span, // Signed span step.
  output logic [31:0] nxt // Address for the next unit.
);
  logic [31:0] unit_bytes;
  logic [31:0] span_ext;

  // The span step is sign extended; the unit size never depends on it.
  assign unit_bytes = 32'h0000_0001 << tw; // R13
  assign span_ext = {{24{span[7]}}, span}; // R11

  // Wraparound walks upward like increment; the reload is done by the engine.
  always_comb begin
    unique case (mode)
      DCS_AM_FIX: nxt = addr;
      // A misaligned span is passed on unchanged; keeping it aligned is up to software.
      DCS_AM_SPAN: nxt = addr + span_ext; // R12 R14
      default: nxt = addr + unit_bytes;
    endcase
  end
endmodule : dcs_addr_step

/* dcs_bus_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// System bus slave seen by the channel's master port.
module dcs_bus_model (
  input wire logic clock, // System clock.
  input wire logic resetn, // Reset, active low.
  input wire logic slow, // Adds three wait cycles to every answer.
  input wire logic m_req, // Request from the channel.
  input wire logic m_write, // Request is a write.
  input wire logic [31:0] m_addr, // Request address.
  input wire logic [1:0] m_size, // Unit width.
  input wire logic [31:0] m_wdata, // Write data.
  output logic [31:0] m_rdata, // Read data, valid with the acknowledge.
  output logic m_ack, // One-cycle completion pulse.
  output logic m_err, // Error response beside the acknowledge.
  output logic [31:0] rd_last, // Address of the last read.
  output logic [31:0] wr_last, // Address of the last write.
  output logic [31:0] wd_last, // Data of the last write.
  output logic [1:0] sz_last // Width of the last unit.
);
  logic [1:0] wait_q;
  // Read data toggles outside an answer, so a stale word never looks valid.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 2'd0;
      m_ack <= 1'b0;
      m_err <= 1'b0;
      m_rdata <= 32'h0000_0000;
      rd_last <= 32'h0000_0000;
      wr_last <= 32'h0000_0000;
      wd_last <= 32'h0000_0000;
      sz_last <= 2'd0;
    end else begin
      m_ack <= 1'b0;
      m_err <= 1'b0;
      m_rdata <= ~m_rdata;
      if (m_req && !m_ack) begin
        wait_q <= wait_q + 2'd1;
        if (!slow || wait_q == 2'd3) begin
          wait_q <= 2'd0;
          m_ack <= 1'b1;
          m_err <= m_addr[31];
          m_rdata <= m_addr ^ 32'hA5A5_0000;
          sz_last <= m_size;
          if (m_write) begin
            wr_last <= m_addr;
            wd_last <= m_wdata;
          end else begin
            rd_last <= m_addr;
          end
        end
      end
    end
  end
endmodule : dcs_bus_model

/* dcs_channel.sv */
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
// Function
// R1: Flags bit 31 shows the live level of the channel interrupt output.
// R2: In wrap mode, remaining count reaching zero sets wrap pattern 0001.
// R3: In wrap mode, remaining count at half the programmed count sets 0100.
// R4: A wrap flag bit clears only when software writes one to it.
// R5: Block-done flag is set on completion, zero while running or idle; here it stays set in idle after completion until a one is written.
// R6: Writing one to the block-done bit clears it.
// R7: A bus error response on a read or write sets the abort flag.
// R8: A bus error stops the transfer and returns the engine to idle.
// R9: After an abort software resets the channel and restarts the transfer.
// R10: Abort flag clears on a written one; a written zero does nothing.
// R11: The span field is a signed two's-complement value, -128 to 127.
// R12: A spanned pointer has the signed span added on every transfer.
// R13: Transfer size comes from the width setting, never from the span.
// R14: Software keeps the span a multiple of the transfer width.
// R15: With done enable set, completion raises the interrupt output.
// R16: With wrap enable set, selected wrap events raise the interrupt output.
// R17: Reserved bits read as zero and ignore writes.
module dcs_channel
  import dcs_pkg::*;
#(
  parameter int CNT_W = 16 // Width of the transfer count.
) (
  input wire logic clock, // System clock, 100 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size, word only.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  output logic [31:0] hrdata, // AHB read data.
  output logic irq, // Channel interrupt, level.
  output logic m_req, // Master request, held until acknowledged.
  output logic m_write, // Master request is a write.
  output logic [31:0] m_addr, // Master address.
  output logic [1:0] m_size, // Master unit width.
  output logic [31:0] m_wdata, // Master write data.
  input wire logic [31:0] m_rdata, // Master read data.
  input wire logic m_ack, // Master request completed.
  input wire logic m_err // Completion carried an error response.
);
  typedef enum logic [1:0] {DCS_IDLE, DCS_RD, DCS_WR} dcs_state_t;

  logic ap_wr_q, ap_rd_q, ce;
  logic [7:0] ap_ad_q;
  logic [31:0] hrdata_q, rmux;
  dcs_amode_t smode_q, dmode_q;
  logic [1:0] tw_q, wsel_q;
  logic [CNT_W-1:0] count_q, rem_q, rem_nxt;
  logic [7:0] span_q;
  logic [2:0] ien_q;
  logic [31:0] sbase_q, dbase_q, sadr_q, dadr_q, data_q, sadr_nxt, dadr_nxt;
  dcs_state_t state_q;
  logic abort_q, done_q;
  logic [3:0] wrap_q;
  logic wen, start, chrst, rd_ok, wr_ok, err_evt, end_evt, wrap_act;
  logic wrap_end_set, half_set, done_set;
  logic [31:0] clr_w;
  logic [30:0] unused_bits;

  assign ce = clk_en;
  assign unused_bits = {haddr[31:8], hsize, htrans[0], hwdata[31:29]};

  // ==========================================================================
  // AHB-Lite slave. Zero wait states while enabled; a low enable stretches the
  // data phase so that no write is dropped while the block is frozen.
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Address phase capture.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_ad_q <= 8'h00;
    end else if (ce && hready) begin
      ap_wr_q <= hsel && htrans == DCS_HTRANS_NONSEQ && hwrite;
      ap_rd_q <= hsel && htrans == DCS_HTRANS_NONSEQ && !hwrite;
      ap_ad_q <= {haddr[7:2], 2'b00};
    end
  end

  assign wen = ce && ap_wr_q;
  assign start = wen && ap_ad_q == DCS_OFF_CTRL && hwdata[DCS_CTL_START];
  assign chrst = wen && ap_ad_q == DCS_OFF_CTRL && hwdata[DCS_CTL_CHRST];
  // Ones written to the flags or clear register clear the matching flags.
  assign clr_w = (wen && (ap_ad_q == DCS_OFF_FLAGS || ap_ad_q == DCS_OFF_CLR)) ? hwdata : DCS_RST_WORD;

  // Read multiplexer; unmapped and reserved bits read as zero.
  always_comb begin
    rmux = DCS_RST_WORD; // R17
    unique case ({haddr[7:2], 2'b00})
      DCS_OFF_CTRL: rmux[9:2] = {wsel_q, tw_q, dmode_q, smode_q};
      DCS_OFF_COUNT: rmux[CNT_W-1:0] = count_q;
      DCS_OFF_SPANSET: rmux[7:0] = span_q;
      DCS_OFF_IEN: rmux[2:0] = ien_q;
      DCS_OFF_SBASE: rmux = sbase_q;
      DCS_OFF_DBASE: rmux = dbase_q;
      DCS_OFF_STAT: rmux[DCS_STAT_BUSY:0] = {state_q != DCS_IDLE, rem_q};
      DCS_OFF_FLAGS: rmux = {irq, 19'h0_0000, wrap_q, 6'h00, done_q, abort_q}; // R1
      DCS_OFF_SPAN: rmux[7:0] = span_q;
      default: rmux = DCS_RST_WORD;
    endcase
  end

  // Read data is sampled at the address phase and held through the data phase.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hrdata_q <= DCS_RST_WORD;
    end else if (ce && hready && hsel && htrans == DCS_HTRANS_NONSEQ && !hwrite) begin
      hrdata_q <= rmux;
    end
  end

  // ==========================================================================
  // Configuration registers written by software.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      smode_q <= DCS_AM_INC;
      dmode_q <= DCS_AM_INC;
      tw_q <= 2'h0;
      wsel_q <= 2'h0;
      count_q <= '0;
      span_q <= 8'h00;
      ien_q <= 3'h0;
      sbase_q <= DCS_RST_WORD;
      dbase_q <= DCS_RST_WORD;
    end else if (wen) begin
      unique case (ap_ad_q)
        DCS_OFF_CTRL: begin
          smode_q <= dcs_amode_t'(hwdata[DCS_CTL_SMODE+:2]);
          dmode_q <= dcs_amode_t'(hwdata[DCS_CTL_DMODE+:2]);
          tw_q <= hwdata[DCS_CTL_TW+:2]; // R13
          wsel_q <= hwdata[DCS_CTL_WSEL+:2];
        end
        DCS_OFF_COUNT: count_q <= hwdata[CNT_W-1:0];
        DCS_OFF_SPANSET: span_q <= hwdata[7:0]; // R11
        DCS_OFF_IEN: ien_q <= hwdata[2:0];
        DCS_OFF_SBASE: sbase_q <= hwdata;
        DCS_OFF_DBASE: dbase_q <= hwdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Transfer engine: one read then one write per unit.
  dcs_addr_step u_src_step (.addr(sadr_q), .mode(smode_q), .tw(tw_q), .span(span_q), .nxt(sadr_nxt));
  dcs_addr_step u_dst_step (.addr(dadr_q), .mode(dmode_q), .tw(tw_q), .span(span_q), .nxt(dadr_nxt));

  assign rd_ok = ce && state_q == DCS_RD && m_ack && !m_err;
  assign wr_ok = ce && state_q == DCS_WR && m_ack && !m_err;
  assign err_evt = ce && state_q != DCS_IDLE && m_ack && m_err; // R7
  assign rem_nxt = rem_q - 1'b1;
  assign end_evt = wr_ok && rem_nxt == '0;
  assign wrap_act = smode_q == DCS_AM_WRAP || dmode_q == DCS_AM_WRAP;
  assign wrap_end_set = end_evt && wrap_act && wsel_q[0]; // R2
  assign half_set = wr_ok && wrap_act && wsel_q[1] && rem_nxt == (count_q >> 1); // R3
  assign done_set = end_evt && !wrap_act;

  assign m_req = state_q != DCS_IDLE;
  assign m_write = state_q == DCS_WR;
  assign m_addr = (state_q == DCS_WR) ? dadr_q : sadr_q;
  assign m_size = tw_q; // R13
  assign m_wdata = data_q;

  // A zero count never starts. A wraparound channel reloads and keeps running.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= DCS_IDLE;
      sadr_q <= DCS_RST_WORD;
      dadr_q <= DCS_RST_WORD;
      rem_q <= '0;
      data_q <= DCS_RST_WORD;
    end else if (ce) begin
      if (chrst || err_evt) begin
        state_q <= DCS_IDLE; // R8
      end else if (start && state_q == DCS_IDLE && count_q != '0) begin
        state_q <= DCS_RD;
        sadr_q <= sbase_q;
        dadr_q <= dbase_q;
        rem_q <= count_q;
      end else if (rd_ok) begin
        data_q <= m_rdata;
        sadr_q <= sadr_nxt; // R12
        state_q <= DCS_WR;
      end else if (wr_ok) begin
        if (end_evt && wrap_act) begin
          sadr_q <= sbase_q;
          dadr_q <= dbase_q;
          rem_q <= count_q;
          state_q <= DCS_RD;
        end else begin
          dadr_q <= dadr_nxt; // R12
          rem_q <= rem_nxt;
          state_q <= end_evt ? DCS_IDLE : DCS_RD;
        end
      end
    end
  end

  // ==========================================================================
  // Sticky flags. A set in the same cycle as a clear wins, so no event is lost.
  // Starting a transfer drops the done flag so it reads zero while running.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      abort_q <= 1'b0;
      done_q <= 1'b0;
      wrap_q <= 4'h0;
    end else if (ce) begin
      abort_q <= err_evt || (abort_q && !clr_w[DCS_FLG_ABORT]); // R7 R10
      done_q <= done_set || (done_q && !clr_w[DCS_FLG_DONE] && !start); // R5 R6
      wrap_q <= (wrap_end_set ? DCS_WRAP_END : 4'h0) | (half_set ? DCS_WRAP_HALF : 4'h0) |
                (wrap_q & ~clr_w[DCS_FLG_WRAP_LO+:4]); // R2 R3 R4
    end
  end

  // Interrupt line, also visible as bit 31 of the flags register.
  assign irq = (abort_q && ien_q[DCS_IEN_ABORT]) || (done_q && ien_q[DCS_IEN_DONE]) || // R15
               ((|wrap_q) && ien_q[DCS_IEN_WRAP]); // R16

  // ==========================================================================
  // Assertions.
  sequence s_flag_read;
    ce && hready && hsel && htrans == DCS_HTRANS_NONSEQ && !hwrite && haddr[7:0] == DCS_OFF_FLAGS;
  endsequence
  sequence s_bus_err;
    state_q != DCS_IDLE ##0 ce && m_ack && m_err;
  endsequence

  a_irq_view: assert property (@(posedge clock) disable iff (!resetn) // R1
    s_flag_read |=> hrdata[DCS_FLG_IRQ] == $past(irq) && hrdata[30:12] == 19'h0_0000 && hrdata[7:2] == 6'h00)
    else $error("flags read does not show the interrupt line or reserved bits");
  a_wrap_end: assert property (@(posedge clock) disable iff (!resetn) // R2
    wrap_end_set && !chrst && !wen |=> wrap_q[0] && state_q == DCS_RD && rem_q == count_q)
    else $error("wrap end flag or reload missing");
  a_wrap_half: assert property (@(posedge clock) disable iff (!resetn) // R3
    half_set |=> wrap_q[2] && rem_q == (count_q >> 1))
    else $error("wrap half flag missing");
  a_wrap_hold: assert property (@(posedge clock) disable iff (!resetn) // R4
    ce |=> (wrap_q & $past(wrap_q & ~clr_w[11:8])) == $past(wrap_q & ~clr_w[11:8]))
    else $error("wrap flag lost without a written one");
  a_done_set: assert property (@(posedge clock) disable iff (!resetn) // R5
    done_set |=> done_q && state_q == DCS_IDLE && !m_req)
    else $error("block done not flagged at completion");
  a_done_clear: assert property (@(posedge clock) disable iff (!resetn) // R6
    ce && clr_w[DCS_FLG_DONE] && !done_set |=> !done_q)
    else $error("block done did not clear on a written one");
  a_abort_stop: assert property (@(posedge clock) disable iff (!resetn) // R7 R8
    s_bus_err |=> abort_q && !m_req ##1 (state_q == DCS_IDLE || $past(start)))
    else $error("bus error did not abort and idle the channel");
  a_abort_keep: assert property (@(posedge clock) disable iff (!resetn) // R10
    abort_q && !clr_w[DCS_FLG_ABORT] |=> abort_q)
    else $error("abort flag cleared without a written one");
  a_span_add: assert property (@(posedge clock) disable iff (!resetn) // R11 R12
    rd_ok && smode_q == DCS_AM_SPAN |=> sadr_q == $past(sadr_q) + {{24{$past(span_q[7])}}, $past(span_q)})
    else $error("span step not added to source address");
  a_done_irq: assert property (@(posedge clock) disable iff (!resetn) // R15
    done_set && ien_q[DCS_IEN_DONE] && !wen |=> irq)
    else $error("completion did not raise the interrupt");
  a_wrap_irq: assert property (@(posedge clock) disable iff (!resetn) // R16
    (wrap_end_set || half_set) && ien_q[DCS_IEN_WRAP] && !wen |=> irq [*2])
    else $error("wrap event did not raise the interrupt");
endmodule : dcs_channel

/* dcs_pkg.sv */
// ==========================================================================
// Shared constants for the channel status and span block.
package dcs_pkg;
  // ==========================================================================
  // Register byte offsets (address bits 7:2 are decoded).
  localparam logic [7:0] DCS_OFF_CTRL = 8'h00;
  localparam logic [7:0] DCS_OFF_COUNT = 8'h04;
  localparam logic [7:0] DCS_OFF_SPANSET = 8'h08;
  localparam logic [7:0] DCS_OFF_IEN = 8'h0C;
  localparam logic [7:0] DCS_OFF_SBASE = 8'h10;
  localparam logic [7:0] DCS_OFF_DBASE = 8'h14;
  localparam logic [7:0] DCS_OFF_STAT = 8'h18;
  localparam logic [7:0] DCS_OFF_CLR = 8'h1C;
  localparam logic [7:0] DCS_OFF_FLAGS = 8'h24;
  localparam logic [7:0] DCS_OFF_SPAN = 8'h34;
  // ==========================================================================
  // Field positions.
  localparam int DCS_FLG_ABORT = 0;
  localparam int DCS_FLG_DONE = 1;
  localparam int DCS_FLG_WRAP_LO = 8;
  localparam int DCS_FLG_IRQ = 31;
  localparam int DCS_IEN_ABORT = 0;
  localparam int DCS_IEN_DONE = 1;
  localparam int DCS_IEN_WRAP = 2;
  localparam int DCS_CTL_START = 0;
  localparam int DCS_CTL_CHRST = 1;
  localparam int DCS_CTL_SMODE = 2;
  localparam int DCS_CTL_DMODE = 4;
  localparam int DCS_CTL_TW = 6;
  localparam int DCS_CTL_WSEL = 8;
  localparam int DCS_STAT_BUSY = 16;
  // ==========================================================================
  // Encodings and reset values.
  localparam logic [3:0] DCS_WRAP_END = 4'h1;
  localparam logic [3:0] DCS_WRAP_HALF = 4'h4;
  localparam logic [31:0] DCS_RST_WORD = 32'h0000_0000;
  localparam logic [1:0] DCS_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {DCS_AM_INC, DCS_AM_FIX, DCS_AM_WRAP, DCS_AM_SPAN} dcs_amode_t;
endpackage : dcs_pkg

/* dma_channel_status_and_span_tb.sv */
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the channel status and span block.
module dma_channel_status_and_span_tb;
  import dcs_pkg::*;
  logic clock, resetn, clk_en, hsel, hwrite, hready, hreadyout, hresp, irq, slow;
  logic [31:0] haddr, hwdata, hrdata, m_addr, m_wdata, m_rdata, rd_last, wr_last, wd_last, d;
  logic [1:0] htrans, m_size, sz_last;
  logic [2:0] hsize;
  logic m_req, m_write, m_ack, m_err;
  int err_count, checks_done;
  // The one slave's ready is the bus ready.
  assign hready = hreadyout;
  dcs_channel u_dut (.clock(clock), .resetn(resetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .m_req(m_req), .m_write(m_write),
    .m_addr(m_addr), .m_size(m_size), .m_wdata(m_wdata), .m_rdata(m_rdata), .m_ack(m_ack), .m_err(m_err));
  dcs_bus_model u_mem (.clock(clock), .resetn(resetn), .slow(slow), .m_req(m_req), .m_write(m_write),
    .m_addr(m_addr), .m_size(m_size), .m_wdata(m_wdata), .m_rdata(m_rdata), .m_ack(m_ack), .m_err(m_err),
    .rd_last(rd_last), .wr_last(wr_last), .wd_last(wd_last), .sz_last(sz_last));
  // ==========================================================================
  // Clock and common tasks.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // A wait that runs out counts as a mismatch and ends the run.
  task automatic ran_out;
    chk(32'h0000_0000, 32'h0000_0001);
    print_verdict();
  endtask : ran_out
  task automatic rdy;
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (hready === 1'b1) break;
    end
    if (n == 50) ran_out();
  endtask : rdy
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= DCS_HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h0000_0000, v);
  endtask : rd
  // Irq is combinational, so it is looked at on the falling edge.
  task automatic wait_irq;
    int n;
    for (n = 0; n < 400; n++) begin
      @(negedge clock);
      if (irq === 1'b1) break;
    end
    if (n == 400) ran_out();
    @(posedge clock);
  endtask : wait_irq
  task automatic xfer(input logic [31:0] ctl, input logic [31:0] cnt, input logic [31:0] sb, input logic [31:0] db);
    wr(DCS_OFF_COUNT, cnt);
    wr(DCS_OFF_SBASE, sb);
    wr(DCS_OFF_DBASE, db);
    wr(DCS_OFF_CTRL, ctl);
    wait_irq();
  endtask : xfer
  // ==========================================================================
  // Scenarios.
  task automatic t_regs;
    rd(DCS_OFF_FLAGS, d); chk(d, DCS_RST_WORD);
    rd(DCS_OFF_SPAN, d); chk(d, DCS_RST_WORD);
    rd(8'h40, d); chk(d, 32'h0000_0000);
    wr(DCS_OFF_SPANSET, 32'hFFFF_FFF8);
    wr(DCS_OFF_SPAN, 32'h0000_0055);
    rd(DCS_OFF_SPAN, d); chk(d, 32'h0000_00F8);
    chk({31'h0, hresp}, 32'h0000_0000);
    // A low enable freezes the block and stalls the bus.
    clk_en <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk({31'h0, hreadyout}, 32'h0000_0000);
    @(posedge clock);
    clk_en <= 1'b1;
    @(posedge clock);
    rd(DCS_OFF_SPAN, d); chk(d, 32'h0000_00F8);
  endtask : t_regs
  // Word source spanned by minus eight, then byte destination spanned by plus 127.
  task automatic t_span;
    wr(DCS_OFF_IEN, 32'h0000_0002);
    xfer(32'h0000_008D, 32'h0000_0002, 32'h0000_0100, 32'h0000_0200);
    chk(rd_last, 32'h0000_00F8);
    chk(wr_last, 32'h0000_0204);
    chk(wd_last, 32'hA5A5_00F8);
    chk({30'h0, sz_last}, 32'h0000_0002);
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h8000_0002);
    wr(DCS_OFF_FLAGS, 32'hFFFF_FFFD);
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h8000_0002);
    wr(DCS_OFF_FLAGS, 32'h0000_0002);
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h0000_0000);
    wr(DCS_OFF_SPANSET, 32'h0000_007F);
    xfer(32'h0000_0031, 32'h0000_0002, 32'h0000_0300, 32'h0000_0400);
    chk(wr_last, 32'h0000_047F);
    chk(rd_last, 32'h0000_0301);
    chk({30'h0, sz_last}, 32'h0000_0000);
    wr(DCS_OFF_FLAGS, 32'h0000_0002);
  endtask : t_span
  task automatic t_abort;
    wr(DCS_OFF_IEN, 32'h0000_0001);
    xfer(32'h0000_0081, 32'h0000_0002, 32'h8000_0000, 32'h0000_0200);
    rd(DCS_OFF_STAT, d); chk(d & 32'h0001_FFFF, 32'h0000_0002);
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h8000_0001);
    wr(DCS_OFF_FLAGS, 32'h0000_0000);
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h8000_0001);
    wr(DCS_OFF_FLAGS, 32'h0000_0001);
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h0000_0000);
    wr(DCS_OFF_CTRL, 32'h0000_0002);
    wr(DCS_OFF_IEN, 32'h0000_0002);
    xfer(32'h0000_0081, 32'h0000_0001, 32'h0000_0100, 32'h0000_0200);
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h8000_0002);
    wr(DCS_OFF_FLAGS, 32'h0000_0002);
  endtask : t_abort
  // Wrapping source with both selects and a slow far side.
  task automatic t_wrap;
    int n;
    slow <= 1'b1;
    wr(DCS_OFF_IEN, 32'h0000_0004);
    wr(DCS_OFF_COUNT, 32'h0000_0004);
    wr(DCS_OFF_SBASE, 32'h0000_0100);
    wr(DCS_OFF_CTRL, 32'h0000_0389);
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h0000_0000);
    wait_irq();
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h8000_0400);
    for (n = 0; n < 50; n++) begin
      rd(DCS_OFF_FLAGS, d);
      if (d[8] === 1'b1) break;
    end
    chk(d, 32'h8000_0500);
    wr(DCS_OFF_CTRL, 32'h0000_0002);
    wr(DCS_OFF_FLAGS, 32'h0000_0100);
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h8000_0400);
    wr(DCS_OFF_FLAGS, 32'h0000_0400);
    rd(DCS_OFF_FLAGS, d); chk(d, 32'h0000_0000);
    slow <= 1'b0;
  endtask : t_wrap
  // ==========================================================================
  // Main sequence.
  initial begin
    err_count = 0;
    checks_done = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    slow = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_regs();
    t_span();
    t_abort();
    t_wrap();
    print_verdict();
  end
endmodule : dma_channel_status_and_span_tb
